/* File: core/nic_ctrl.sv */
// Nested vectored interrupt controller with APB registers and sleep control.
// Assumes peripheral lines and core strobes synchronous to pclk, one-cycle
// core strobes, and an APB master that follows the usual two-phase transfer.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`include "nic_cfg.svh"
// How it works
// - Fifty-two peripheral request inputs, each an independent source.
// - One priority of eight levels is held per source.
// - Each line is level or edge sensitive, chosen per source.
// - The highest ranked eligible pending request goes to the core.
// - Sources not above a nonzero masking level are blocked.
// - Vector addresses are built from a software-written base offset.
// - One request line per peripheral, whatever it combines inside.
// - System exceptions and peripheral lines share one ranking.
// - In deep sleep a wake unit keeps detecting and wakes the core.
// - With sleep after handler set, last handler return enters sleep.
// - Wait for interrupt, wait for event and send event are served.
// - A later higher request replaces the presented one until taken.
module nic_ctrl #(
   parameter int N_EXT = `NIC_N_EXT,
   parameter int N_SYS = `NIC_N_SYS,
   parameter int PW = `NIC_PW,
   parameter int IW = `NIC_IW
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request sources
   input wire logic [N_EXT-1:0] irq_line,
   input wire logic [N_SYS-1:0] sys_exc,
   // Core side
   input wire nic_pkg::nic_core_s core_in,
   output nic_pkg::nic_irq_s irq_out,
   output logic core_sleep,
   output logic core_wake,
   output logic event_out
);
   localparam int N = N_EXT + N_SYS;

   // ************
   // State
   // ************
   logic [N_EXT-1:0] en_r;
   logic [N_EXT-1:0] edge_r;
   logic [N_EXT-1:0] line_q_r;
   logic [N-1:0] pend_r;
   logic [N-1:0] act_r;
   logic [N-1:0][PW-1:0] prio_r;
   logic [PW-1:0] mask_r;
   logic [31:0] vbase_r;
   logic sah_r;
   logic deep_r;
   logic evt_r;
   logic wfe_wait_r;
   nic_pkg::nic_slp_e st_r;
   nic_pkg::nic_slp_e st_nxt;
   nic_pkg::nic_irq_s irq_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic sleep_r;
   logic wake_r;
   logic evt_out_r;

   // ************
   // APB decode
   // ************
   logic setup;
   logic wr_go;
   logic prio_wr;
   logic [2:0] prio_w;
   logic addr_ok;
   logic [31:0] rd_val;
   logic [63:0] wr_wide;

   assign setup = psel & ~penable;
   assign wr_go = psel & penable & pready_r & pwrite;
   assign prio_w = paddr[4:2];
   assign prio_wr = wr_go && paddr[11:5] == `NIC_OFS_PRIO_HI && prio_w < `NIC_PRIO_WORDS;
   assign wr_wide = paddr[2] ? {pwdata, 32'h0} : {32'h0, pwdata};

   // ************
   // Request detection
   // ************
   logic freeze;
   logic [N_EXT-1:0] rise;
   logic [N_EXT-1:0] edge_hit;
   logic [N_EXT-1:0] lvl_hit;
   logic [N_EXT-1:0] hw_ext;
   logic [N_EXT-1:0] sw_set;
   logic [N_EXT-1:0] sw_clr;
   logic [N-1:0] set_vec;
   logic [N-1:0] clr_vec;
   logic [N-1:0] en_all;
   logic [N-1:0] ok;
   logic [N-1:0] elig;
   logic [N-1:0] eoi_oh;
   logic [N-1:0] ack_oh;
   logic wk_wake;
   logic [N-1:0] wk_caught;

   // Main detection stands still in deep sleep; the wake unit covers it
   assign freeze = st_r == nic_pkg::nic_st_deep;
   assign rise = irq_line & ~line_q_r;
   assign edge_hit = edge_r & rise;
   assign lvl_hit = ~edge_r & irq_line;
   assign hw_ext = edge_hit | lvl_hit;
   assign sw_set = (wr_go && paddr[11:3] == `NIC_OFS_SETPEND0 >> 3) ?
                   wr_wide[N_EXT-1:0] : '0;
   assign sw_clr = (wr_go && paddr[11:3] == `NIC_OFS_CLRPEND0 >> 3) ?
                   wr_wide[N_EXT-1:0] : '0;
   assign ack_oh = (core_in.ack && irq_r.valid) ? N'(1) << irq_r.id : '0;
   assign eoi_oh = core_in.eoi ? N'(1) << core_in.eoi_id : '0;
   assign set_vec = {(freeze ? {N_EXT{1'b0}} : hw_ext) | sw_set, sys_exc} |
                    (wk_wake ? wk_caught : '0);
   assign clr_vec = {sw_clr, {N_SYS{1'b0}}} | ack_oh;
   assign en_all = {en_r, {N_SYS{1'b1}}};

   // ************
   // Ranking
   // ************
   logic hit;
   logic [IW-1:0] win_id;
   logic [PW-1:0] win_prio;
   logic act_hit;
   logic [PW-1:0] run_prio;
   logic [7:0] vec_num;

   for (genvar i = 0; i < N; i++) begin : g_ok
      // Lower value is more urgent; a zero mask level masks nothing
      assign ok[i] = (mask_r == '0 || prio_r[i] < mask_r) &&
                     (!act_hit || prio_r[i] < run_prio);
   end
   assign elig = pend_r & en_all & ok;

   nic_prio_arb #(.N(N), .PW(PW), .IW(IW)) u_pend_arb (
      .req(elig),
      .prio(prio_r),
      .hit(hit),
      .idx(win_id),
      .best(win_prio)
   );

   nic_prio_arb #(.N(N), .PW(PW), .IW(IW)) u_act_arb (
      .req(act_r),
      .prio(prio_r),
      .hit(act_hit),
      .idx(),
      .best(run_prio)
   );

   nic_wake_unit #(.N(N), .PW(PW), .IW(IW)) u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .armed(freeze),
      .lines({irq_line, sys_exc}),
      .enable(en_all),
      .prio(prio_r),
      .wake_r(wk_wake),
      .wake_id_r(),
      .caught_r(wk_caught)
   );

   assign vec_num = (win_id < IW'(N_SYS)) ? 8'(win_id) + `NIC_SYS_VEC_OFS :
                    8'(win_id) + `NIC_EXT_VEC_OFS;

   // ************
   // Configuration registers
   // ************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= '0;
         edge_r <= '0;
         mask_r <= '0;
         vbase_r <= `NIC_RST_VBASE;
         sah_r <= 1'b0;
         deep_r <= 1'b0;
      end else if (wr_go) begin
         case (paddr)
            `NIC_OFS_ENABLE0, `NIC_OFS_ENABLE1: begin
               for (int i = 0; i < N_EXT; i++) begin
                  if ((i >= 32) == paddr[2]) begin
                     en_r[i] <= wr_wide[i];
                  end
               end
            end
            `NIC_OFS_EDGE0, `NIC_OFS_EDGE1: begin
               for (int i = 0; i < N_EXT; i++) begin
                  if ((i >= 32) == paddr[2]) begin
                     edge_r[i] <= wr_wide[i];
                  end
               end
            end
            `NIC_OFS_MASK: mask_r <= pwdata[PW-1:0];
            `NIC_OFS_VBASE: vbase_r <= pwdata & `NIC_VBASE_KEEP;
            `NIC_OFS_CTRL: begin
               sah_r <= pwdata[`NIC_CTRL_SAH];
               deep_r <= pwdata[`NIC_CTRL_DEEP];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_r <= {N{`NIC_RST_PRIO}};
      end else begin
         for (int i = 0; i < N_EXT; i++) begin
            if (prio_wr && prio_w == 3'(i / 8)) begin
               prio_r[i+N_SYS] <= pwdata[(i%8)*4 +: PW];
            end
         end
         for (int i = 0; i < N_SYS; i++) begin
            if (wr_go && paddr == `NIC_OFS_SYSPRI) begin
               prio_r[i] <= pwdata[i*4 +: PW];
            end
         end
      end
   end

   // ************
   // Pending and active
   // ************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q_r <= '0;
      end else if (!freeze) begin
         line_q_r <= irq_line;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= '0;
      end else begin
         // A new request in the clearing cycle is kept
         pend_r <= (pend_r & ~clr_vec) | set_vec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= '0;
      end else begin
         act_r <= (act_r & ~eoi_oh) | ack_oh;
      end
   end

   // ************
   // Presentation to the core
   // ************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= '0;
      end else begin
         // Re-ranked every cycle, so a late urgent arrival takes the slot
         irq_r.valid <= hit & ~(core_in.ack & irq_r.valid);
         irq_r.id <= win_id;
         irq_r.prio <= win_prio;
         irq_r.vec_addr <= vbase_r + {22'h0, vec_num, 2'b00};
      end
   end

   // ************
   // Sleep and events
   // ************
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         nic_pkg::nic_st_run: begin
            if (core_in.wait_interrupt_instr || (core_in.wait_event_instr && !evt_r) ||
                (core_in.eoi && sah_r && (act_r & ~eoi_oh) == '0)) begin
               st_nxt = deep_r ? nic_pkg::nic_st_deep : nic_pkg::nic_st_slp;
            end
         end
         nic_pkg::nic_st_slp: begin
            if (hit || (wfe_wait_r && evt_r)) begin
               st_nxt = nic_pkg::nic_st_run;
            end
         end
         nic_pkg::nic_st_deep: begin
            if (wk_wake) begin
               st_nxt = nic_pkg::nic_st_run;
            end
         end
         default: st_nxt = nic_pkg::nic_st_run;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= nic_pkg::nic_st_run;
         sleep_r <= 1'b0;
         wake_r <= 1'b0;
         wfe_wait_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sleep_r <= st_nxt != nic_pkg::nic_st_run;
         wake_r <= st_r != nic_pkg::nic_st_run && st_nxt == nic_pkg::nic_st_run;
         if (st_r == nic_pkg::nic_st_run) begin
            wfe_wait_r <= core_in.wait_event_instr && !evt_r && !core_in.wait_interrupt_instr;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_r <= 1'b0;
         evt_out_r <= 1'b0;
      end else begin
         evt_out_r <= core_in.send_event_instr;
         // Set wins over consumption by wait for event
         if (core_in.send_event_instr || (set_vec & ~pend_r) != '0) begin
            evt_r <= 1'b1;
         end else if ((st_r == nic_pkg::nic_st_run && core_in.wait_event_instr) ||
                      (st_r == nic_pkg::nic_st_slp && wfe_wait_r)) begin
            evt_r <= 1'b0;
         end
      end
   end

   // ************
   // Register read and bus answer
   // ************
   always_comb begin
      rd_val = 32'h0;
      addr_ok = 1'b1;
      if (paddr[11:5] == `NIC_OFS_PRIO_HI && prio_w < `NIC_PRIO_WORDS) begin
         for (int j = 0; j < 8; j++) begin
            if (32'(prio_w) * 8 + j < N_EXT) begin
               rd_val[j*4 +: PW] = prio_r[32'(prio_w) * 8 + j + N_SYS];
            end
         end
      end else begin
         case (paddr)
            `NIC_OFS_ENABLE0: rd_val = en_r[31:0];
            `NIC_OFS_ENABLE1: rd_val = 32'(en_r[N_EXT-1:32]);
            `NIC_OFS_SETPEND0, `NIC_OFS_CLRPEND0: rd_val = pend_r[N_SYS +: 32];
            `NIC_OFS_SETPEND1, `NIC_OFS_CLRPEND1: rd_val = 32'(pend_r[N-1:N_SYS+32]);
            `NIC_OFS_EDGE0: rd_val = edge_r[31:0];
            `NIC_OFS_EDGE1: rd_val = 32'(edge_r[N_EXT-1:32]);
            `NIC_OFS_SYSPRI: begin
               for (int j = 0; j < N_SYS; j++) begin
                  rd_val[j*4 +: PW] = prio_r[j];
               end
            end
            `NIC_OFS_MASK: rd_val = 32'(mask_r);
            `NIC_OFS_VBASE: rd_val = vbase_r;
            `NIC_OFS_CTRL: rd_val = {30'h0, deep_r, sah_r};
            `NIC_OFS_STATUS: rd_val = {6'h0, sleep_r, act_hit, 5'h0, run_prio,
                                       7'h0, irq_r.valid, 2'h0, irq_r.id};
            default: addr_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~addr_ok;
         if (setup && !pwrite) begin
            prdata_r <= rd_val;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq_out = irq_r;
   assign core_sleep = sleep_r;
   assign core_wake = wake_r;
   assign event_out = evt_out_r;

   // ************
   // Checks
   // ************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_sw_set_pend: assert property (
      (wr_go && paddr == `NIC_OFS_SETPEND0 && pwdata[0]) |=> pend_r[N_SYS])
      else $error("software set did not pend line 0");
   chk_edge_pend: assert property (
      (!freeze && edge_hit != '0) |=>
      (pend_r[N-1:N_SYS] & $past(edge_hit)) == $past(edge_hit))
      else $error("rising edge did not pend its line");
   chk_level_pend: assert property (
      (!freeze && lvl_hit != '0) |=>
      (pend_r[N-1:N_SYS] & $past(lvl_hit)) == $past(lvl_hit))
      else $error("high level did not pend its line");
   chk_present_win: assert property (
      (hit && !(core_in.ack && irq_r.valid)) |=> irq_out.valid && irq_out.id == $past(win_id))
      else $error("winner not presented");
   chk_mask_level: assert property (
      irq_out.valid && $past(mask_r) != 3'h0 |-> irq_out.prio < $past(mask_r))
      else $error("masked priority presented");
   chk_vec_base: assert property (
      irq_out.valid |-> irq_out.vec_addr == $past(vbase_r) + 32'(irq_out.id) * 32'd4 +
                        (irq_out.id < 6'd4 ? 32'd8 : 32'd48))
      else $error("vector address not built from base");
   chk_sleep_exit: assert property (
      (st_r == nic_pkg::nic_st_run && core_in.eoi && sah_r && (act_r & ~eoi_oh) == '0)
      |=> core_sleep ##1 (core_sleep || core_wake))
      else $error("no sleep after last handler");
   chk_deep_wake: assert property (
      (freeze && wk_wake) |=> !core_sleep && core_wake)
      else $error("wake unit did not wake core");
   chk_send_event: assert property (
      core_in.send_event_instr |=> event_out && evt_r)
      else $error("send event not signalled");
endmodule : nic_ctrl

/* File: core/nic_cfg.svh */
// Offsets, field positions, reset values and sizes of the interrupt controller.
// Assumes a 12-bit APB byte address, one 32-bit register per aligned word.
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH
// ************
// Sizes
// ************
`define NIC_N_EXT 52
`define NIC_N_SYS 4
`define NIC_PW 3
`define NIC_IW 6
// ************
// Register offsets
// ************
`define NIC_OFS_ENABLE0 12'h000
`define NIC_OFS_ENABLE1 12'h004
`define NIC_OFS_SETPEND0 12'h010
`define NIC_OFS_SETPEND1 12'h014
`define NIC_OFS_CLRPEND0 12'h020
`define NIC_OFS_CLRPEND1 12'h024
`define NIC_OFS_EDGE0 12'h030
`define NIC_OFS_EDGE1 12'h034
`define NIC_OFS_PRIO_HI 7'h02
`define NIC_PRIO_WORDS 3'h7
`define NIC_OFS_SYSPRI 12'h060
`define NIC_OFS_MASK 12'h070
`define NIC_OFS_VBASE 12'h074
`define NIC_OFS_CTRL 12'h078
`define NIC_OFS_STATUS 12'h07c
// ************
// Fields and reset values
// ************
`define NIC_CTRL_SAH 0
`define NIC_CTRL_DEEP 1
`define NIC_VBASE_KEEP 32'hffffff80
`define NIC_RST_PRIO 3'h0
`define NIC_RST_VBASE 32'h00000000
`define NIC_SYS_VEC_OFS 8'h02
`define NIC_EXT_VEC_OFS 8'h0c
`endif

/* File: core/nic_pkg.sv */
// Types shared by the interrupt controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package nic_pkg;
   typedef enum logic [2:0] {
      nic_st_run = 3'b001,
      nic_st_slp = 3'b010,
      nic_st_deep = 3'b100
   } nic_slp_e;
   typedef struct packed {
      logic ack;
      logic eoi;
      logic [5:0] eoi_id;
      logic wait_interrupt_instr;
      logic wait_event_instr;
      logic send_event_instr;
   } nic_core_s;
   typedef struct packed {
      logic valid;
      logic [5:0] id;
      logic [2:0] prio;
      logic [31:0] vec_addr;
   } nic_irq_s;
endpackage : nic_pkg

/* File: core/nic_prio_arb.sv */
// Priority picker: lowest priority value wins, lowest index breaks ties.
// Assumes a flat vector of equal-width priority fields, one per request.
`timescale 1ns/100ps
module nic_prio_arb #(
   parameter int N = 56,
   parameter int PW = 3,
   parameter int IW = 6
) (
   // Requests
   input wire logic [N-1:0] req,
   input wire logic [N*PW-1:0] prio,
   // Winner
   output logic hit,
   output logic [IW-1:0] idx,
   output logic [PW-1:0] best
);
   always_comb begin
      hit = 1'b0;
      idx = '0;
      best = '1;
      for (int i = 0; i < N; i++) begin
         // Strict compare keeps the earlier index on a tie
         if (req[i] && (!hit || prio[i*PW +: PW] < best)) begin
            hit = 1'b1;
            idx = IW'(i);
            best = prio[i*PW +: PW];
         end
      end
   end
endmodule : nic_prio_arb

/* File: core/nic_wake_unit.sv */
// Wake-up companion: catches enabled lines while the main logic is frozen.
// Assumes the caller arms it only during deep sleep and merges caught lines.
`timescale 1ns/100ps
`include "nic_cfg.svh"
module nic_wake_unit #(
   parameter int N = 56,
   parameter int PW = 3,
   parameter int IW = 6
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control and sources
   input wire logic armed,
   input wire logic [N-1:0] lines,
   input wire logic [N-1:0] enable,
   input wire logic [N*PW-1:0] prio,
   // Results
   output logic wake_r,
   output logic [IW-1:0] wake_id_r,
   output logic [N-1:0] caught_r
);
   logic [N-1:0] seen;
   logic hit;
   logic [IW-1:0] idx;

   assign seen = caught_r | (lines & enable);

   nic_prio_arb #(.N(N), .PW(PW), .IW(IW)) u_arb (
      .req(seen),
      .prio(prio),
      .hit(hit),
      .idx(idx),
      .best()
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         caught_r <= '0;
      end else if (armed) begin
         caught_r <= seen;
      end else begin
         caught_r <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_r <= 1'b0;
         wake_id_r <= '0;
      end else begin
         wake_r <= armed & hit;
         wake_id_r <= idx;
      end
   end
endmodule : nic_wake_unit

/* File: verification/nic_core_model.sv */
// Behavioural core: takes presented interrupts, returns from handlers, issues strobes.
// Assumes the controller's one-cycle strobe contract on core_in.
`timescale 1ns/100ps
module nic_core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench controls
   input wire logic hold,
   input wire logic slow,
   input wire logic cmd_wfi,
   input wire logic cmd_sev,
   input wire logic cmd_wfe,
   // Controller side
   input wire nic_pkg::nic_irq_s irq,
   output nic_pkg::nic_core_s core,
   output logic [5:0] last_id,
   output logic [31:0] last_vec,
   output logic [7:0] takes
);
   nic_pkg::nic_core_s nxt;
   logic [5:0] stk [0:7];
   int depth;
   int age;
   // ****************
   // Take and return
   // ****************
   // Handlers nest on a small stack; the newest returns first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core <= '0;
         last_id <= '0;
         last_vec <= '0;
         takes <= '0;
         depth = 0;
         age = 0;
      end else begin
         nxt = '0;
         nxt.wait_interrupt_instr = cmd_wfi;
         nxt.send_event_instr = cmd_sev;
         nxt.wait_event_instr = cmd_wfe;
         age = age + 1;
         if (core.ack) begin
            last_id <= irq.id;
            last_vec <= irq.vec_addr;
            takes <= takes + 8'h01;
            stk[depth] = irq.id;
            depth = depth + 1;
            age = 0;
         end else if (irq.valid && !hold && (!slow || age > 3)) begin
            nxt.ack = 1'b1;
         end else if (depth > 0 && age > 4) begin
            depth = depth - 1;
            nxt.eoi = 1'b1;
            nxt.eoi_id = stk[depth];
            age = 0;
         end
         core <= nxt;
      end
   end
endmodule : nic_core_model

/* File: verification/nested_vectored_irq_ctrl_test.sv */
// Self-checking bench: APB master, request lines and a behavioural core.
// Assumes the design files and the core model are compiled before it.
`timescale 1ns/100ps
`include "nic_cfg.svh"
module nested_vectored_irq_ctrl_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold, slow;
   logic cmd_wfi, cmd_sev, cmd_wfe, core_sleep, core_wake, event_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, base, last_vec;
   logic [51:0] irq_line;
   logic [3:0] sys_exc;
   logic [5:0] last_id;
   logic [7:0] takes, t0;
   logic [2:0] prio_sh [0:51];
   nic_pkg::nic_core_s core_in;
   nic_pkg::nic_irq_s irq_out;
   int fails, comparisons, cycles, ev_n, wk_n, seed, a, b, w;

   nic_ctrl u_nic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_line(irq_line), .sys_exc(sys_exc), .core_in(core_in),
      .irq_out(irq_out), .core_sleep(core_sleep), .core_wake(core_wake),
      .event_out(event_out));
   nic_core_model u_nic_core_model (.pclk(pclk), .presetn(presetn), .hold(hold),
      .slow(slow), .cmd_wfi(cmd_wfi), .cmd_sev(cmd_sev), .cmd_wfe(cmd_wfe), .irq(irq_out),
      .core(core_in),
      .last_id(last_id), .last_vec(last_vec), .takes(takes));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Pulse counters and hang guard
   always @(posedge pclk) begin
      cycles++;
      if (event_out === 1'b1) ev_n++;
      if (core_wake === 1'b1) wk_n++;
      if (cycles == 60000) begin
         fails++;
         give_verdict();
      end
   end
   // ****************
   // Tasks
   // ****************
   task automatic give_verdict();
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] ad, input logic [31:0] exp, input string what);
      apb(1'b0, ad, 32'h0);
      chk(what, exp, rd);
   endtask : rdc
   function automatic logic [31:0] prio_word(input int l);
      logic [31:0] d;
      d = '0;
      for (int k = 0; k < 8; k++) if (l / 8 * 8 + k < 52) d[k*4+:3] = prio_sh[l / 8 * 8 + k];
      return d;
   endfunction : prio_word
   task automatic put_prio(input int l);
      apb(1'b1, 12'h040 + 12'(l / 8 * 4), prio_word(l));
   endtask : put_prio
   task automatic pend(input int l);
      apb(1'b1, l < 32 ? `NIC_OFS_SETPEND0 : `NIC_OFS_SETPEND1, 32'h1 << (l % 32));
   endtask : pend
   task automatic wait_take();
      t0 = takes;
      while (takes === t0) @(posedge pclk);
      @(negedge pclk);
   endtask : wait_take
   // Kind 0 waits for interrupt, 1 sends an event, 2 waits for an event
   task automatic pulse(input int kind);
      @(posedge pclk);
      cmd_wfi <= kind == 0;
      cmd_sev <= kind == 1;
      cmd_wfe <= kind == 2;
      @(posedge pclk);
      {cmd_wfi, cmd_sev, cmd_wfe} <= 3'h0;
      repeat (4) @(posedge pclk);
   endtask : pulse
   function automatic logic [31:0] lvec(input int l);
      return base + 32'(4 * (l + 16));
   endfunction : lvec
   // ****************
   // Main sequence
   // ****************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, cmd_wfi, cmd_sev, cmd_wfe, slow} = '0;
      {presetn, irq_line, sys_exc} = '0;
      hold = 1'b1;
      {fails, comparisons, cycles, ev_n, wk_n} = '0;
      seed = 24794;
      foreach (prio_sh[i]) prio_sh[i] = 3'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`NIC_OFS_CTRL, 32'h0, "ctrl");
      rdc(`NIC_OFS_MASK, 32'h0, "mask");
      rdc(`NIC_OFS_VBASE, 32'h0, "vbase");
      apb(1'b1, 12'h100, 32'h1);
      chk("write error", 32'h1, {31'h0, err});
      apb(1'b0, 12'h100, 32'h0);
      chk("read error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, `NIC_OFS_VBASE, 32'h200003ff);
      base = 32'h20000380;
      rdc(`NIC_OFS_VBASE, base, "vbase");
      apb(1'b1, `NIC_OFS_ENABLE0, 32'hffffffff);
      apb(1'b1, `NIC_OFS_ENABLE1, 32'h000fffff);
      // Random pairs, the second arriving while the first is shown
      for (int i = 0; i < 12; i++) begin
         a = {$random(seed)} % 52;
         b = (a + 1 + {$random(seed)} % 51) % 52;
         prio_sh[a] = 3'($random(seed));
         prio_sh[b] = 3'($random(seed));
         slow <= i % 2;
         put_prio(a);
         put_prio(b);
         rdc(12'h040 + 12'(a / 8 * 4), prio_word(a), "prio word");
         pend(a);
         repeat (4) @(posedge pclk);
         pend(b);
         w = (prio_sh[b] < prio_sh[a] || (prio_sh[b] == prio_sh[a] && b < a)) ? b : a;
         hold <= 1'b0;
         wait_take();
         chk("first id", 32'(w + 4), 32'(last_id));
         chk("first vector", lvec(w), last_vec);
         wait_take();
         chk("second id", 32'(a + b - w + 4), 32'(last_id));
         hold <= 1'b1;
      end
      prio_sh[5] = 3'h3;
      prio_sh[6] = 3'h2;
      prio_sh[7] = 3'h0;
      put_prio(5);
      apb(1'b1, `NIC_OFS_MASK, 32'h3);
      hold <= 1'b0;
      t0 = takes;
      pend(5);
      repeat (30) @(posedge pclk);
      chk("masked takes", 32'(t0), 32'(takes));
      rdc(`NIC_OFS_SETPEND0, 32'h20, "pending");
      pend(6);
      wait_take();
      chk("unmasked id", 32'd10, 32'(last_id));
      apb(1'b1, `NIC_OFS_CLRPEND0, 32'h20);
      apb(1'b1, `NIC_OFS_MASK, 32'h0);
      irq_line[7] <= 1'b1;
      wait_take();
      chk("level id", 32'd11, 32'(last_id));
      irq_line[7] <= 1'b0;
      repeat (30) @(posedge pclk);
      apb(1'b1, `NIC_OFS_EDGE1, 32'h100);
      irq_line[40] <= 1'b1;
      wait_take();
      repeat (40) @(posedge pclk);
      chk("edge id", 32'd44, 32'(last_id));
      chk("edge takes", 32'(t0 + 8'h01), 32'(takes));
      irq_line[40] <= 1'b0;
      hold <= 1'b1;
      sys_exc[1] <= 1'b1;
      put_prio(0);
      pend(0);
      hold <= 1'b0;
      wait_take();
      sys_exc[1] <= 1'b0;
      chk("system id", 32'd1, 32'(last_id));
      chk("system vector", base + 32'hc, last_vec);
      repeat (40) @(posedge pclk);
      chk("line after system", 32'd4, 32'(last_id));
      pulse(1'b1);
      chk("event count", 32'd1, 32'(ev_n));
      pulse(2);
      chk("event consumed", 32'h0, {31'h0, core_sleep});
      pulse(2);
      chk("event sleep", 32'h1, {31'h0, core_sleep});
      pulse(1);
      chk("event wake", 32'd1, 32'(wk_n));
      hold <= 1'b1;
      pulse(1'b0);
      chk("light sleep", 32'h1, {31'h0, core_sleep});
      pend(9);
      repeat (5) @(posedge pclk);
      chk("light wake", 32'd2, 32'(wk_n));
      hold <= 1'b0;
      wait_take();
      chk("wake id", 32'd13, 32'(last_id));
      apb(1'b1, `NIC_OFS_CTRL, 32'h2);
      pulse(1'b0);
      chk("deep sleep", 32'h1, {31'h0, core_sleep});
      irq_line[3] <= 1'b1;
      repeat (20) @(posedge pclk);
      irq_line[3] <= 1'b0;
      chk("deep wake", 32'd3, 32'(wk_n));
      chk("deep id", 32'd7, 32'(last_id));
      // Let level re-takes of line 3 drain before a handler return may sleep
      repeat (40) @(posedge pclk);
      apb(1'b1, `NIC_OFS_CTRL, 32'h1);
      chk("awake before handler", 32'h0, {31'h0, core_sleep});
      pend(2);
      repeat (30) @(posedge pclk);
      chk("sleep after handler", 32'h1, {31'h0, core_sleep});
      apb(1'b1, `NIC_OFS_CTRL, 32'h0);
      pend(12);
      repeat (30) @(posedge pclk);
      chk("handler wake", 32'd4, 32'(wk_n));
      chk("awake", 32'h0, {31'h0, core_sleep});
      give_verdict();
   end
endmodule : nested_vectored_irq_ctrl_test
